// file: shared/sgcr_map.vh
// Address map, field positions, reset values and timing of the global control bank.
// Assumes an 8-bit register port and a 250 MHz core clock.
`ifndef SGCR_MAP_VH
`define SGCR_MAP_VH

// ==========================================================
// Register offsets
`define SGCR_OFS_HOST_CFG     8'h06
`define SGCR_OFS_STORM_LOW    8'h07
`define SGCR_OFS_FACTORY_A    8'h08
`define SGCR_OFS_FACTORY_B    8'h0A
`define SGCR_OFS_CLK_EDGE     8'h0B

// ==========================================================
// Host port configuration fields
`define SGCR_BIT_BACK_PRESS   7
`define SGCR_BIT_HALF_DUPLEX  6
`define SGCR_BIT_FLOW_CTRL    5
`define SGCR_BIT_SPEED_10M    4
`define SGCR_BIT_NULL_VID     3
`define SGCR_STORM_HI_MSB     2
`define SGCR_STORM_HI_RST     3'h0
`define SGCR_STORM_LO_RST     8'h4A

// ==========================================================
// Clock edge fields
`define SGCR_BIT_THIRD_NEG    7
`define SGCR_BIT_FOURTH_NEG   6
`define SGCR_BIT_MGMT_FALL    0

// ==========================================================
// Timing
`define SGCR_CLK_MHZ          250
`define SGCR_STORM_100M_MS    50
`define SGCR_STORM_10M_MS     500
`define SGCR_STRAP_SETTLE     3'h4
// Period counts at the core clock: 50 ms is 12,500,000 cycles, 500 ms is ten of them
`define SGCR_STORM_100M_CYCLES 24'hBEBC20
`define SGCR_STORM_10M_RATIO   4'hA

`endif

// file: core/sgcr_regs.v
// Global control register bank of the switch: host port setup, storm threshold,
// storm measuring period and sampling edge selects.
// Assumes the management interface delivers single-cycle read and write strobes
// on clk_i; strap pins arrive asynchronously.
`timescale 1ns/100ps
`include "sgcr_map.vh"

module sgcr_regs #(
  parameter [23:0] STORM_100M_CYCLES = `SGCR_STORM_100M_CYCLES,
  parameter [3:0]  STORM_10M_RATIO   = `SGCR_STORM_10M_RATIO
) (
  // Clock and reset
  input  wire        clk_i,
  input  wire        reset_n_i,
  // Register port
  input  wire [7:0]  reg_addr_i,
  input  wire        reg_wr_i,
  input  wire [7:0]  reg_wdata_i,
  input  wire        reg_rd_i,
  output reg  [7:0]  reg_rdata_o,
  output reg         reg_rvalid_o,
  // Strap pins
  input  wire        duplex_strap_pin_i,
  input  wire        flow_ctrl_strap_pin_i,
  input  wire        speed_strap_pin_i,
  // Fourth MAC host port controls
  output reg         host_back_pressure_o,
  output reg         host_half_duplex_o,
  output reg         host_flow_ctrl_o,
  output reg         host_speed_10m_o,
  // Switch controls
  output reg         null_vid_replace_o,
  output reg  [10:0] storm_threshold_o,
  output reg         storm_tick_100m_o,
  output reg         storm_tick_10m_o,
  // Sampling edge selects
  output reg         third_mac_rmii_negedge_o,
  output reg         fourth_mac_rmii_negedge_o,
  output reg         mgmt_read_falling_o
);

  // Keep the current value unless both late sync stages agree
  function sgcr_pick;
    input s2;
    input s3;
    input cur;
    begin
      sgcr_pick = (s2 == s3) ? s2 : cur;
    end
  endfunction

  // ==========================================================
  // Reset release
  reg rst_meta;
  reg rst_n;

  always @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      rst_meta <= 1'b0;
      rst_n    <= 1'b0;
    end else begin
      rst_meta <= 1'b1;
      rst_n    <= rst_meta;
    end
  end

  // ==========================================================
  // Strap synchronisers
  // Stage 1 may go metastable, so only stages 2 and 3 are compared
  reg [2:0] strap_s1;
  reg [2:0] strap_s2;
  reg [2:0] strap_s3;
  reg [2:0] strap_wait;
  wire      strap_busy = (strap_wait != `SGCR_STRAP_SETTLE);

  always @(posedge clk_i or negedge rst_n) begin
    if (!rst_n) begin
      strap_s1   <= 3'h0;
      strap_s2   <= 3'h0;
      strap_s3   <= 3'h0;
      strap_wait <= 3'h0;
    end else begin
      strap_s1 <= {duplex_strap_pin_i, flow_ctrl_strap_pin_i, speed_strap_pin_i};
      strap_s2 <= strap_s1;
      strap_s3 <= strap_s2;
      if (strap_busy) begin
        strap_wait <= strap_wait + 3'h1;
      end
    end
  end

  // ==========================================================
  // Register writes
  wire wr_host  = reg_wr_i && (reg_addr_i == `SGCR_OFS_HOST_CFG);
  wire wr_storm = reg_wr_i && (reg_addr_i == `SGCR_OFS_STORM_LOW);
  wire wr_edge  = reg_wr_i && (reg_addr_i == `SGCR_OFS_CLK_EDGE);

  // Straps are sampled right after release; host writes to the strap bits
  // only take hold once the settle window has passed.
  always @(posedge clk_i or negedge rst_n) begin
    if (!rst_n) begin
      host_back_pressure_o      <= 1'b0;
      host_half_duplex_o        <= 1'b0;
      host_flow_ctrl_o          <= 1'b0;
      host_speed_10m_o          <= 1'b0;
      null_vid_replace_o        <= 1'b0;
      storm_threshold_o         <= {`SGCR_STORM_HI_RST, `SGCR_STORM_LO_RST};
      third_mac_rmii_negedge_o  <= 1'b0;
      fourth_mac_rmii_negedge_o <= 1'b0;
      mgmt_read_falling_o       <= 1'b0;
    end else begin
      if (strap_busy) begin
        host_half_duplex_o <= sgcr_pick(strap_s2[2], strap_s3[2], host_half_duplex_o);
        host_flow_ctrl_o   <= sgcr_pick(strap_s2[1], strap_s3[1], host_flow_ctrl_o);
        host_speed_10m_o   <= sgcr_pick(strap_s2[0], strap_s3[0], host_speed_10m_o);
      end else if (wr_host) begin
        host_half_duplex_o <= reg_wdata_i[`SGCR_BIT_HALF_DUPLEX];
        host_flow_ctrl_o   <= reg_wdata_i[`SGCR_BIT_FLOW_CTRL];
        host_speed_10m_o   <= reg_wdata_i[`SGCR_BIT_SPEED_10M];
      end
      if (wr_host) begin
        host_back_pressure_o       <= reg_wdata_i[`SGCR_BIT_BACK_PRESS];
        null_vid_replace_o         <= reg_wdata_i[`SGCR_BIT_NULL_VID];
        storm_threshold_o[10:8]    <= reg_wdata_i[`SGCR_STORM_HI_MSB:0];
      end
      if (wr_storm) begin
        storm_threshold_o[7:0] <= reg_wdata_i;
      end
      if (wr_edge) begin
        third_mac_rmii_negedge_o  <= reg_wdata_i[`SGCR_BIT_THIRD_NEG];
        fourth_mac_rmii_negedge_o <= reg_wdata_i[`SGCR_BIT_FOURTH_NEG];
        mgmt_read_falling_o       <= reg_wdata_i[`SGCR_BIT_MGMT_FALL];
      end
    end
  end

  // ==========================================================
  // Register reads
  reg [7:0] next_rdata;

  // Factory test, reserved and unmapped locations all read zero
  always @* begin
    next_rdata = 8'h00;
    case (reg_addr_i)
      `SGCR_OFS_HOST_CFG: begin
        next_rdata[`SGCR_BIT_BACK_PRESS]  = host_back_pressure_o;
        next_rdata[`SGCR_BIT_HALF_DUPLEX] = host_half_duplex_o;
        next_rdata[`SGCR_BIT_FLOW_CTRL]   = host_flow_ctrl_o;
        next_rdata[`SGCR_BIT_SPEED_10M]   = host_speed_10m_o;
        next_rdata[`SGCR_BIT_NULL_VID]    = null_vid_replace_o;
        next_rdata[`SGCR_STORM_HI_MSB:0]  = storm_threshold_o[10:8];
      end
      `SGCR_OFS_STORM_LOW: begin
        next_rdata = storm_threshold_o[7:0];
      end
      `SGCR_OFS_CLK_EDGE: begin
        next_rdata[`SGCR_BIT_THIRD_NEG]  = third_mac_rmii_negedge_o;
        next_rdata[`SGCR_BIT_FOURTH_NEG] = fourth_mac_rmii_negedge_o;
        next_rdata[`SGCR_BIT_MGMT_FALL] = mgmt_read_falling_o;
      end
      default: begin
        next_rdata = 8'h00;
      end
    endcase
  end

  // A read in the same cycle as a write returns the value from before the write
  always @(posedge clk_i or negedge rst_n) begin
    if (!rst_n) begin
      reg_rdata_o  <= 8'h00;
      reg_rvalid_o <= 1'b0;
    end else begin
      reg_rvalid_o <= reg_rd_i;
      if (reg_rd_i) begin
        reg_rdata_o <= next_rdata;
      end
    end
  end

  // ==========================================================
  // Storm measuring periods
  // The 500 ms tick is a decade of 50 ms ticks, so both periods stay aligned.
  // Both ticks always run; whoever meters a port picks the one for its speed.
  reg [23:0] period_cnt;
  reg [3:0]  decade_cnt;
  wire       period_end = (period_cnt == STORM_100M_CYCLES - 24'h1);
  wire       decade_end = (decade_cnt == STORM_10M_RATIO - 4'h1);

  always @(posedge clk_i or negedge rst_n) begin
    if (!rst_n) begin
      period_cnt        <= 24'h000000;
      decade_cnt        <= 4'h0;
      storm_tick_100m_o <= 1'b0;
      storm_tick_10m_o  <= 1'b0;
    end else begin
      storm_tick_100m_o <= period_end;
      storm_tick_10m_o  <= period_end && decade_end;
      if (period_end) begin
        period_cnt <= 24'h000000;
        decade_cnt <= decade_end ? 4'h0 : decade_cnt + 4'h1;
      end else begin
        period_cnt <= period_cnt + 24'h000001;
      end
    end
  end

endmodule

// file: verif/sgcr_strap_model.sv
// Far-side strap resistors on the host port receive lines.
// Assumes the pins are read only during the settle window after reset.
`timescale 1ns/100ps
module sgcr_strap_model (
  input  wire [2:0] pull_up_i,
  output wire [2:0] pin_o
);
  // An unfitted resistor leaves the internal pull-down, so a clear request reads low
  assign pin_o = pull_up_i;
endmodule

// file: verif/sgcr_regs_sva.sv
// Port checker for the global control bank.
// Assumes single-cycle strobes on clk_i.
`timescale 1ns/100ps
module sgcr_regs_chk (
  input wire        clk_i,
  input wire        reset_n_i,
  input wire [7:0]  reg_addr_i,
  input wire        reg_wr_i,
  input wire [7:0]  reg_wdata_i,
  input wire        reg_rd_i,
  input wire [7:0]  reg_rdata_o,
  input wire        reg_rvalid_o,
  input wire        host_back_pressure_o,
  input wire        null_vid_replace_o,
  input wire [10:0] storm_threshold_o,
  input wire        storm_tick_100m_o,
  input wire        storm_tick_10m_o,
  input wire        third_mac_rmii_negedge_o
);
  default clocking @(posedge clk_i); endclocking
  default disable iff (!reset_n_i);
  read_answer_a: assert property (reg_rd_i |=> reg_rvalid_o) else $error("read not answered");
  back_press_a: assert property (reg_wr_i && reg_addr_i == 8'h06 |=>
    host_back_pressure_o == $past(reg_wdata_i[7])) else $error("back pressure bit wrong");
  null_vid_a: assert property (reg_wr_i && reg_addr_i == 8'h06 |=>
    null_vid_replace_o == $past(reg_wdata_i[3])) else $error("null vid bit wrong");
  storm_high_a: assert property (reg_wr_i && reg_addr_i == 8'h06 |=>
    storm_threshold_o[10:8] == $past(reg_wdata_i[2:0])) else $error("storm high wrong");
  storm_low_a: assert property (reg_wr_i && reg_addr_i == 8'h07 |=>
    storm_threshold_o[7:0] == $past(reg_wdata_i)) else $error("storm low wrong");
  storm_hold_a: assert property (!reg_wr_i |=> $stable(storm_threshold_o)) else $error("storm moved");
  third_edge_a: assert property (reg_wr_i && reg_addr_i == 8'h0B |=>
    third_mac_rmii_negedge_o == $past(reg_wdata_i[7])) else $error("third mac edge wrong");
  factory_zero_a: assert property (reg_rd_i && (reg_addr_i == 8'h08 || reg_addr_i == 8'h0A) |=>
    reg_rdata_o == 8'h00) else $error("factory register not zero");
  tick_align_a: assert property (storm_tick_10m_o |-> storm_tick_100m_o) else $error("slow tick alone");
endmodule
bind sgcr_regs sgcr_regs_chk u_chk (.clk_i(clk_i), .reset_n_i(reset_n_i), .reg_addr_i(reg_addr_i),
  .reg_wr_i(reg_wr_i), .reg_wdata_i(reg_wdata_i), .reg_rd_i(reg_rd_i), .reg_rdata_o(reg_rdata_o),
  .reg_rvalid_o(reg_rvalid_o), .host_back_pressure_o(host_back_pressure_o),
  .null_vid_replace_o(null_vid_replace_o), .storm_threshold_o(storm_threshold_o),
  .storm_tick_100m_o(storm_tick_100m_o), .storm_tick_10m_o(storm_tick_10m_o),
  .third_mac_rmii_negedge_o(third_mac_rmii_negedge_o));

// file: verif/tb_sgcr_regs.sv
// Random register traffic against a shadow copy, plus straps and storm ticks.
// Assumes a shortened storm period.
`timescale 1ns/100ps
`include "sgcr_map.vh"
module tb_sgcr_regs;
  localparam P = 8;
  logic clk_i = 0, reset_n_i = 0, reg_wr_i = 0, reg_rd_i = 0;
  logic [7:0] reg_addr_i = 0, reg_wdata_i = 0, h, l, c, a, d, q;
  logic [2:0] pu = 3'b101, pin;
  wire [7:0] reg_rdata_o;
  wire [10:0] thr;
  wire rv, bp, hd, fc, sp, nv, t1, t10, m3, m4, mg;
  integer mismatches = 0, n_checks = 0, i, n;
  logic [7:0] adr [0:6] = '{8'h06, 8'h07, 8'h08, 8'h09, 8'h0A, 8'h0B, 8'h3C};
  always #2 clk_i = ~clk_i;
  sgcr_strap_model PM (.pull_up_i(pu), .pin_o(pin));
  sgcr_regs #(.STORM_100M_CYCLES(24'd8)) DUT (.clk_i(clk_i), .reset_n_i(reset_n_i), .reg_addr_i(reg_addr_i),
    .reg_wr_i(reg_wr_i), .reg_wdata_i(reg_wdata_i), .reg_rd_i(reg_rd_i), .reg_rdata_o(reg_rdata_o),
    .reg_rvalid_o(rv), .duplex_strap_pin_i(pin[2]), .flow_ctrl_strap_pin_i(pin[1]),
    .speed_strap_pin_i(pin[0]), .host_back_pressure_o(bp), .host_half_duplex_o(hd),
    .host_flow_ctrl_o(fc), .host_speed_10m_o(sp), .null_vid_replace_o(nv), .storm_threshold_o(thr),
    .storm_tick_100m_o(t1), .storm_tick_10m_o(t10), .third_mac_rmii_negedge_o(m3),
    .fourth_mac_rmii_negedge_o(m4), .mgmt_read_falling_o(mg));
  task chk(input string nm, input logic [10:0] s, input logic [10:0] e);
    n_checks++;
    if (s !== e) begin
      mismatches++;
      $display("wrong value %s expected %h seen %h", nm, e, s);
    end
  endtask
  function logic [7:0] ex(input logic [7:0] ad);
    case (ad)
      8'h06: ex = h;
      8'h07: ex = l;
      8'h0B: ex = c;
      default: ex = 8'h00;
    endcase
  endfunction
  task outs;
    chk("bp", bp, h[7]);
    chk("hd", hd, h[6]);
    chk("fc", fc, h[5]);
    chk("sp", sp, h[4]);
    chk("nv", nv, h[3]);
    chk("thr", thr, {h[2:0], l});
    chk("m3", m3, c[7]);
    chk("m4", m4, c[6]);
    chk("mg", mg, c[0]);
  endtask
  task op(input logic wr);
    @(posedge clk_i);
    #1 reg_addr_i = a;
    reg_wdata_i = d;
    reg_wr_i = wr;
    reg_rd_i = !wr;
    @(posedge clk_i);
    #1 reg_wr_i = 0;
    reg_rd_i = 0;
    q = reg_rdata_o;
  endtask
  task wt(input logic sel, output integer k);
    k = 0;
    @(posedge clk_i);
    #1;
    while ((sel ? t10 : t1) !== 1'b1 && k < 200) begin
      @(posedge clk_i);
      #1 k++;
    end
  endtask
  task report_and_stop;
    if (mismatches == 0 && n_checks > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  initial begin
    #40000 mismatches++;
    report_and_stop;
  end
  initial begin
    void'($urandom(57));
    repeat (6) @(posedge clk_i);
    #1 reset_n_i = 1;
    repeat (10) @(posedge clk_i);
    #1 pu = 3'b010;
    h = 8'h50;
    l = `SGCR_STORM_LO_RST;
    c = 8'h00;
    outs;
    for (i = 0; i < 60; i++) begin
      a = adr[$urandom % 7];
      d = $urandom;
      op(1);
      if (a == 8'h06) h = d;
      if (a == 8'h07) l = d;
      if (a == 8'h0B) c = d & 8'hC1;
      outs;
      chk("rv", rv, 1'b0);
      op(0);
      chk("rv", rv, 1'b1);
      chk("rd", q, ex(a));
    end
    reset_n_i = 0;
    pu = 3'b011;
    repeat (6) @(posedge clk_i);
    #1 reset_n_i = 1;
    repeat (10) @(posedge clk_i);
    #1 h = {1'h0, pu, 4'h0};
    l = `SGCR_STORM_LO_RST;
    c = 8'h00;
    outs;
    wt(0, n);
    wt(0, n);
    chk("fast", n, P - 1);
    wt(1, n);
    wt(1, n);
    chk("slow", n, P * 10 - 1);
    report_and_stop;
  end
endmodule
